// [cascaded_i2c_slave_regs_tb.sv]
// Purpose: Self-checking bench for the two-wire slave block
// Assumes: Host model drives the bus, APB reads back registers
// Notes: Expected register image kept in exp
`timescale 1ns/100ps
module cascaded_i2c_slave_regs_tb;
  logic clk, rst, psel, penable, pwrite, err, k;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sda_out, sda_oe, scl, sda_pull;
  logic [3:0] user_flags;
  logic [7:0] exp [0:10];
  wire logic sda_w;
  int n_fail, checks_done, seed, ptr;
  // Open-drain wire with pull-up
  assign sda_w = ~(sda_pull | (sda_oe & ~sda_out));
  csr_i2c_slave u_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .casc_scl_out(),
    .casc_sda_out(), .casc_sda_in(1'b1), .user_flags(user_flags)
  );
  csr_host_model u_host (.scl(scl), .sda_pull(sda_pull), .sda(sda_w));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk1(input logic got, input logic want);
    chk({31'h0, got}, {31'h0, want});
  endtask
  // APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Start, slave byte, address byte, no stop
  task automatic set_ptr(input logic [7:0] a);
    u_host.start();
    u_host.send(8'h50, k);
    chk1(k, 1'b1);
    u_host.send(a, k);
    chk1(k, 1'b1);
    ptr = int'(a);
  endtask
  // Write n random bytes from address a
  task automatic i2c_wr(input logic [7:0] a, input int n);
    logic [7:0] d;
    set_ptr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      if (ptr == 10) d[7] = 1'b0;
      u_host.send(d, k);
      chk1(k, 1'b1);
      exp[ptr] = d;
      ptr = (ptr == 10) ? 0 : ptr + 1;
    end
    u_host.stop();
  endtask
  // Read n bytes at pointer, nack the last
  task automatic i2c_rd(input int n);
    logic [7:0] d;
    u_host.start();
    u_host.send(8'h51, k);
    chk1(k, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_host.recv(i < n - 1, d);
      chk({24'h0, d}, {24'h0, exp[ptr]});
      ptr = (ptr == 10) ? 0 : ptr + 1;
    end
    u_host.stop();
  endtask
  task automatic regs_check();
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, 8'h40 + 8'(4 * i), 32'h0);
      chk(rd, {24'h0, exp[i]});
    end
    chk({28'h0, user_flags}, {28'h0, exp[9][3:0]});
  endtask
  ////////////////////////////////////////
  initial begin
    seed = 32;
    n_fail = 0;
    checks_done = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ptr = 0;
    for (int i = 0; i < 11; i++) exp[i] = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    chk1(err, 1'b1);
    apb(1'b1, 8'h44, 32'h0);
    chk1(err, 1'b1);
    regs_check();
    $display("test apb done");
    i2c_wr(8'h08, 4);
    i2c_wr(8'h03, 2);
    regs_check();
    $display("test burst write done");
    i2c_rd(2);
    set_ptr(8'h09);
    i2c_rd(3);
    $display("test reads done");
    u_host.start();
    u_host.send(8'h52, k);
    chk1(k, 1'b0);
    u_host.send(8'h00, k);
    chk1(k, 1'b0);
    u_host.stop();
    apb(1'b1, 8'h00, 32'h3);
    u_host.start();
    u_host.send(8'h52, k);
    chk1(k, 1'b1);
    u_host.stop();
    apb(1'b1, 8'h00, 32'h2);
    $display("test slave match done");
    apb(1'b1, 8'h00, 32'h6);
    apb(1'b1, 8'h00, 32'h2);
    for (int i = 0; i < 11; i++) if (i != 9) exp[i] = 8'h00;
    regs_check();
    set_ptr(8'h0a);
    u_host.send(8'h80, k);
    u_host.stop();
    for (int i = 0; i < 11; i++) exp[i] = 8'h00;
    ptr = 0;
    regs_check();
    i2c_rd(1);
    $display("test sleep and reset done");
    give_verdict();
  end
endmodule // cascaded_i2c_slave_regs_tb

// [csr_host_model.sv]
// Purpose: Behavioural two-wire bus master for the slave bench
// Assumes: Open-drain data line with pull-up, 125 ns bit period
// Notes: Clock stands high between frames
`timescale 1ns/100ps
module csr_host_model (
  // Bus pins
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // One bit slot, data set only with clock low
  task automatic slot(input logic b, output logic r);
    #Q sda_pull = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    #Q sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
  endtask
  // Stop, clock then stands high
  task automatic stop();
    #Q sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask
  // Byte out msb first, line released on ninth clock
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      slot(d[i], r);
    end
    slot(1'b1, r);
    ack = ~r;
  endtask
  // Byte in, then ack or nack
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, r);
      d[i] = r;
    end
    slot(~ack, r);
  endtask
endmodule // csr_host_model

// [csr_i2c_slave.sv]
// Purpose: Two-wire slave with cascade forwarding and small register space
// Assumes: Master makes the serial clock; bus pins are open drain
// Notes: Pins are oversampled by clk after a two-stage synchroniser
`timescale 1ns/100ps
module csr_i2c_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Cascade link
  output logic casc_scl_out,
  output logic casc_sda_out,
  input wire logic casc_sda_in,
  // User flags
  output logic [3:0] user_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [2:0] sync_q;
  logic scl_s, sda_s, ret_s;
  logic scl_d, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [2:0] ctrl;
  logic upper, enable, sleep;
  csr_pkg::csr_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] tx;
  logic [3:0] ptr;
  logic rw;
  logic matched;
  logic acked;
  logic own_pull;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] regs [0:csr_pkg::NUM_REGS-1];
  logic [7:0] rd_byte;
  logic apb_setup;
  logic [31:0] next_prdata;
  logic next_slverr;

  // Register read with zero outside the space
  function automatic logic [7:0] reg_rd(input logic [3:0] idx,
                                        input logic [7:0] r10,
                                        input logic [7:0] r9,
                                        input logic [7:0] lo);
    logic [7:0] v;
    v = 8'h00;
    if (idx == csr_pkg::LAST_REG) begin
      v = r10;
    end else if (idx == csr_pkg::USER_FLAG_REG) begin
      v = r9;
    end else if (idx < csr_pkg::USER_FLAG_REG) begin
      v = lo;
    end
    return v;
  endfunction

  // Pointer step with wrap past the last register
  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    logic [3:0] n;
    n = 4'h0;
    if (p < csr_pkg::LAST_REG) begin
      n = p + 4'h1;
    end
    return n;
  endfunction

  assign upper = ctrl[csr_pkg::CTRL_UPPER_BIT];
  assign enable = ctrl[csr_pkg::CTRL_ENABLE_BIT];
  assign sleep = ctrl[csr_pkg::CTRL_SLEEP_BIT];

  // Byte the current pointer would send next
  assign rd_byte = reg_rd(ptr, regs[10], regs[9], regs[ptr]);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  csr_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({casc_sda_in, sda_in, scl_in}),
    .q(sync_q)
  );

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign ret_s = sync_q[2];

  // Delayed copies for edge finding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Data edges with clock high are start or stop only
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s; // [R04] [R05]
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s; // [R04] [R06]

  ////////////////////////////////////////////////////////////////////////////
  // Bus state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= csr_pkg::CSR_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      tx <= 8'h00;
      ptr <= 4'h0; // [R22]
      rw <= 1'b0;
      matched <= 1'b0;
      acked <= 1'b0;
      own_pull <= 1'b0;
    end else if (!enable || sleep || (wr_en && wr_idx ==
               csr_pkg::FORCE_POR_REG && wr_data[csr_pkg::FORCE_POR_BIT])) begin
      // Disabled, asleep or forced reset: back to standby
      state <= csr_pkg::CSR_IDLE;
      own_pull <= 1'b0;
      matched <= 1'b0;
      if (enable && !sleep) begin
        ptr <= 4'h0;
      end
    end else if (stop_det) begin
      state <= csr_pkg::CSR_IDLE; // [R06]
      own_pull <= 1'b0;
      matched <= 1'b0;
    end else if (start_det) begin
      state <= csr_pkg::CSR_SLAVE; // [R05]
      bit_cnt <= 4'h0;
      own_pull <= 1'b0;
      matched <= 1'b0;
    end else begin
      if (scl_rise) begin
        // Sample on rising clock, first bit is bit 7
        shift_in <= {shift_in[6:0], sda_s}; // [R03]
        bit_cnt <= bit_cnt + 4'h1;
        if (state == csr_pkg::CSR_RACK) begin
          acked <= ~sda_s; // [R09]
        end
      end
      if (scl_fall) begin
        case (state)
          csr_pkg::CSR_SLAVE: begin
            if (bit_cnt == csr_pkg::BITS_PER_BYTE) begin
              if (shift_in[7:1] == (upper ? csr_pkg::SLAVE_ADDR_UPPER :
                  csr_pkg::SLAVE_ADDR_LOWER)) begin // [R19]
                state <= csr_pkg::CSR_SLV_ACK;
                own_pull <= 1'b1; // [R07] [R08]
                rw <= shift_in[0];
                matched <= 1'b1;
              end else begin
                state <= csr_pkg::CSR_IGNORE; // [R21]
              end
            end
          end
          csr_pkg::CSR_SLV_ACK: begin
            bit_cnt <= 4'h0;
            if (rw) begin
              // Read from the current pointer
              tx <= rd_byte; // [R18]
              own_pull <= ~rd_byte[7];
              state <= csr_pkg::CSR_RDATA; // [R03]
            end else begin
              own_pull <= 1'b0;
              state <= csr_pkg::CSR_ADDR; // [R11]
            end
          end
          csr_pkg::CSR_ADDR: begin
            if (bit_cnt == csr_pkg::BITS_PER_BYTE) begin
              ptr <= shift_in[3:0]; // [R15]
              own_pull <= 1'b1; // [R08]
              state <= csr_pkg::CSR_ADDR_ACK;
            end
          end
          csr_pkg::CSR_ADDR_ACK: begin
            own_pull <= 1'b0;
            bit_cnt <= 4'h0;
            state <= csr_pkg::CSR_WDATA;
          end
          csr_pkg::CSR_WDATA: begin
            if (bit_cnt == csr_pkg::BITS_PER_BYTE) begin
              own_pull <= 1'b1; // [R07] [R08]
              state <= csr_pkg::CSR_WDATA_ACK;
            end
          end
          csr_pkg::CSR_WDATA_ACK: begin
            own_pull <= 1'b0;
            bit_cnt <= 4'h0;
            ptr <= ptr_inc(ptr); // [R14]
            state <= csr_pkg::CSR_WDATA;
          end
          csr_pkg::CSR_RDATA: begin
            if (bit_cnt == csr_pkg::BITS_PER_BYTE) begin
              own_pull <= 1'b0; // [R07] [R09]
              ptr <= ptr_inc(ptr); // [R16]
              state <= csr_pkg::CSR_RACK;
            end else begin
              // Next bit goes out while the clock is low
              tx <= {tx[6:0], 1'b0};
              own_pull <= ~tx[6]; // [R03] [R04]
            end
          end
          csr_pkg::CSR_RACK: begin
            bit_cnt <= 4'h0;
            if (acked) begin
              tx <= rd_byte;
              own_pull <= ~rd_byte[7];
              state <= csr_pkg::CSR_RDATA; // [R09]
            end else begin
              own_pull <= 1'b0;
              state <= csr_pkg::CSR_IGNORE; // [R09] [R10]
            end
          end
          csr_pkg::CSR_IDLE, csr_pkg::CSR_IGNORE: begin
            own_pull <= 1'b0; // [R05]
          end
          default: begin
            state <= csr_pkg::CSR_IDLE;
            own_pull <= 1'b0;
          end
        endcase
      end
    end
  end

  // Write strobe at the fall after the eighth data bit
  assign wr_en = enable && !sleep && !start_det && !stop_det && scl_fall &&
                 state == csr_pkg::CSR_WDATA &&
                 bit_cnt == csr_pkg::BITS_PER_BYTE; // [R13]
  assign wr_idx = ptr;
  assign wr_data = shift_in;

  ////////////////////////////////////////////////////////////////////////////
  // Register space
  genvar g;
  generate
    for (g = 0; g < csr_pkg::NUM_REGS; g++) begin : g_reg
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          regs[g] <= csr_pkg::REG_RESET; // [R22]
        end else if (wr_en && wr_idx == csr_pkg::FORCE_POR_REG &&
                     wr_data[csr_pkg::FORCE_POR_BIT]) begin
          regs[g] <= csr_pkg::REG_RESET; // [R02]
        end else if (sleep && g != int'(csr_pkg::USER_FLAG_REG)) begin
          regs[g] <= csr_pkg::REG_RESET; // [R02]
        end else if (wr_en && wr_idx == 4'(g)) begin
          regs[g] <= wr_data; // [R01] [R13]
        end
      end
    end
  endgenerate

  // Flags are registered copies of their register bits, one clock behind
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      user_flags <= 4'h0;
    end else begin
      user_flags <= regs[csr_pkg::USER_FLAG_REG][csr_pkg::USER_FLAG_LSB +:
                    csr_pkg::USER_FLAG_W]; // [R01]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers and cascade forwarding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      casc_scl_out <= 1'b1;
      casc_sda_out <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      // Lower device also passes the upper device's pull-downs back
      sda_oe <= own_pull | (enable & ~upper & ~ret_s); // [R07] [R20]
      casc_scl_out <= upper | ~enable | scl_s; // [R20] [R21]
      casc_sda_out <= upper | ~enable | sda_s; // [R21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  assign apb_setup = psel & ~penable & ~pready;

  // Read data and error decode
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (paddr == csr_pkg::APB_CTRL) begin
      next_prdata[2:0] = ctrl;
    end else if (paddr == csr_pkg::APB_STATUS) begin
      next_prdata[csr_pkg::STAT_BUSY_BIT] = (state != csr_pkg::CSR_IDLE);
      next_prdata[csr_pkg::STAT_MATCH_BIT] = matched;
      next_prdata[csr_pkg::STAT_READ_BIT] = rw;
      next_prdata[csr_pkg::STAT_PTR_LSB +: 4] = ptr;
    end else if (paddr >= csr_pkg::APB_REG_BASE &&
                 paddr <= csr_pkg::APB_REG_LAST &&
                 paddr[1:0] == 2'h0) begin
      next_prdata[7:0] = regs[4'(paddr[5:2])];
      next_slverr = pwrite;
    end else begin
      next_slverr = 1'b1;
    end
  end

  // Answer in the first access cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & next_slverr;
      if (apb_setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Control register write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= csr_pkg::CTRL_RESET;
    end else if (psel && penable && pready && pwrite &&
                 paddr == csr_pkg::APB_CTRL) begin
      ctrl <= pwdata[2:0];
    end
  end

endmodule // csr_i2c_slave

// [csr_i2c_slave_properties.sv]
// Purpose: Port-level assertions for the two-wire slave block
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Serial pins seen raw, before the slave's synchroniser
`timescale 1ns/100ps
module csr_i2c_slave_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Serial and cascade
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic casc_scl_out,
  input wire logic casc_sda_out,
  input wire logic [3:0] user_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // APB answer timing and refusals
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_paired: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ro_refused: assert property (psel && !penable && pwrite &&
    paddr >= 8'h40 && paddr <= 8'h68 |=> pslverr)
    else $error("register window write not refused");
  // Serial pin behaviour
  a_open_drain: assert property (!sda_out)
    else $error("data pin driven high");
  a_ack_width: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data pull too short");
  a_oe_scl_low: assert property (!$stable(sda_oe) |-> !$past(scl_in))
    else $error("data line changed with clock high");
  a_flag_load: assert property (!$stable(user_flags) |->
    !$past(scl_in) && !$past(scl_in, 2))
    else $error("flags changed outside clock low");
  a_casc_follow: assert property ($rose(casc_scl_out) |->
    $past(scl_in, 2) || $past(scl_in, 3) || $past(scl_in, 4))
    else $error("cascade clock not following bus");
  a_casc_data: assert property ($rose(casc_sda_out) |->
    $past(sda_in, 2) || $past(sda_in, 3) || $past(sda_in, 4))
    else $error("cascade data not following bus");
  // Main scenarios
  c_refused: cover property (pslverr);
  c_ack: cover property ($rose(sda_oe));
  c_flags: cover property (!$stable(user_flags));
endmodule // csr_i2c_slave_checker

bind csr_i2c_slave csr_i2c_slave_checker u_chk (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .scl_in, .sda_in, .sda_out, .sda_oe, .casc_scl_out, .casc_sda_out,
  .user_flags
);

// [csr_pkg.sv]
// Purpose: Shared constants for the cascaded two-wire slave register block
// Assumes: 125 MHz system clock, APB register access, 8-bit serial registers
// Notes:
// Notes on behaviour
// [R01] Four user flag bits, host writable individually
// [R02] Flags survive sleep, cleared by forced reset
// [R03] Bytes travel most significant bit first
// [R04] Data changes only with clock low
// [R05] Ignore bus until a start is seen
// [R06] Stop ends transaction, back to standby
// [R07] Receiver pulls data low on ninth clock
// [R08] Ack matching slave byte and all written bytes (code: no ack for the byte that sets bit 7 of 0ah, forced reset wins)
// [R09] Read continues only on ack, else stop
// [R10] Master sends stop after read nack
// [R11] Write is slave, address, then data bytes
// [R12] Master ends write with stop after ack
// [R13] Store data at fall after eighth bit
// [R14] Pointer increments after write, wraps past 0ah
// [R15] Random read: address write, repeated start, read
// [R16] Pointer increments after eighth read bit
// [R17] Master nacks last read byte, then stops
// [R18] Current-address read uses previous pointer
// [R19] Lower answers 0101000x, upper 0101001x
// [R20] Cascade link: one clock, two data lines
// [R21] Lower forwards bus traffic; mismatch ignores till stop (code: a repeated start also ends ignoring)
// [R22] One shared pointer, zero at power-on reset
package csr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial register space
  localparam int NUM_REGS = 11;
  localparam logic [3:0] LAST_REG = 4'ha;
  localparam logic [3:0] USER_FLAG_REG = 4'h9;
  localparam int USER_FLAG_LSB = 0;
  localparam int USER_FLAG_W = 4;
  localparam logic [3:0] FORCE_POR_REG = 4'ha;
  localparam int FORCE_POR_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Slave byte patterns, read/write bit masked off
  localparam logic [6:0] SLAVE_ADDR_LOWER = 7'h28;
  localparam logic [6:0] SLAVE_ADDR_UPPER = 7'h29;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // APB map
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_REG_BASE = 8'h40;
  localparam logic [7:0] APB_REG_LAST = 8'h68;
  localparam int CTRL_UPPER_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_MATCH_BIT = 1;
  localparam int STAT_READ_BIT = 2;
  localparam int STAT_PTR_LSB = 4;

  // Bus state machine
  typedef enum logic [3:0] {
    CSR_IDLE, CSR_SLAVE, CSR_SLV_ACK, CSR_ADDR, CSR_ADDR_ACK,
    CSR_WDATA, CSR_WDATA_ACK, CSR_RDATA, CSR_RACK, CSR_IGNORE
  } csr_state_t;

endpackage

// [csr_sync.sv]
// Purpose: Two flip-flop synchroniser for pins from outside the clock domain
// Assumes: Inputs are slow levels relative to clk
// Notes: Only the second stage may be read by other logic
`timescale 1ns/100ps
module csr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // One two-stage chain per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta[i] <= RST_VAL[i];
          q[i] <= RST_VAL[i];
        end else begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule // csr_sync
